// ### hw/spi_link.sv
// serial-clock side of the port: shifter, bit count, reply register with falling-edge bit select
`timescale 1ns/100ps
module spi_link
	import squib_pkg::*;
(
	// reset from the core side; clears the link asynchronously, all but cnt_r
	input  wire logic             srst,
	// serial pins
	input  wire logic             sclk,
	input  wire logic             cs_n,
	input  wire logic             mosi,
	output logic                  miso,
	output logic                  miso_oe,
	// toward core
	input  wire logic [7:0]       resp,
	output logic      [7:0]       cap_byte,
	output logic      [CNT_W-1:0] cap_cnt,
	output logic                  cap_tog
);
	logic             fresh_r;
	logic [7:0]       sh_r;
	logic [CNT_W-1:0] cnt_r;
	logic [7:0]       tx_r;
	logic             mode_hi_r;
	logic [CNT_W-1:0] fcnt_r;
	logic [CNT_W-1:0] idx;

	// set while deselected so the first rise of a frame restarts the count
	always_ff @(posedge sclk or posedge cs_n or posedge srst) begin
		if (srst) begin
			fresh_r <= 1'b1; // [R23]
		end else if (cs_n) begin
			fresh_r <= 1'b1; // [R24]
		end else begin
			fresh_r <= 1'b0;
		end
	end

	always_ff @(posedge sclk) begin
		if (fresh_r) begin
			cnt_r <= 4'h1; // [R24]
		end else if (cnt_r < CNT_MAX) begin
			cnt_r <= cnt_r + 4'h1;
		end
	end

	always_ff @(posedge sclk or posedge srst) begin
		if (srst) begin
			sh_r <= 8'h00; // [R23]
		end else begin
			sh_r <= {sh_r[6:0], mosi}; // [R8] [R20]
		end
	end

	// capture at select rise; a frame with no clocks counts as zero
	// toggle must start known, else the core never sees a word
	always_ff @(posedge cs_n or posedge srst) begin
		if (srst) begin
			cap_byte <= 8'h00; // [R23]
			cap_cnt  <= 4'h0;
			cap_tog  <= 1'b0;
		end else begin
			cap_byte <= sh_r; // [R21]
			cap_cnt  <= fresh_r ? 4'h0 : cnt_r;
			cap_tog  <= ~cap_tog;
		end
	end

	// reply loaded at select fall; core rebuilds resp every clock, so it must settle before the fall
	always_ff @(negedge cs_n or posedge srst) begin
		if (srst) begin
			tx_r      <= 8'h00; // [R23]
			mode_hi_r <= 1'b0;
		end else begin
			tx_r      <= resp; // [R21] [R14]
			mode_hi_r <= sclk; // [R6] [R7]
		end
	end

	always_ff @(negedge sclk or posedge cs_n or posedge srst) begin
		if (srst) begin
			fcnt_r <= 4'h0; // [R23]
		end else if (cs_n) begin
			fcnt_r <= 4'h0;
		end else if (fcnt_r < CNT_MAX) begin
			fcnt_r <= fcnt_r + 4'h1; // [R8]
		end
	end

	// idle-high mode: first fall comes before any data rise, so it does not advance
	assign idx     = (fcnt_r == 4'h0) ? 4'h0 : fcnt_r - {3'h0, mode_hi_r}; // [R7]
	assign miso    = (idx < WORD_LEN) ? tx_r[3'(7 - idx)] : 1'b0; // [R20]
	assign miso_oe = ~cs_n; // [R9]
endmodule // spi_link

// ### hw/squib_spi_command_port.sv
// command decode, result pipeline and arm/fire sequencing of the squib port
`timescale 1ns/100ps
module squib_spi_command_port
	import squib_pkg::*;
#(
	// variant bit value is arbitrary here
	parameter logic VARIANT_ID = 1'b0
) (
	// core clock and reset
	input  wire logic       clk,
	input  wire logic       srst,
	// serial pins
	input  wire logic       sclk,
	input  wire logic       cs_n,
	input  wire logic       mosi,
	output logic            serial_result_out_pin,
	output logic            serial_result_out_oe,
	// analog result levels
	input  wire logic [1:0] fen,
	input  wire logic [3:0] low_side_path_ok,
	input  wire logic [7:0] meas_result,
	// diagnostic mode controls
	output logic            low_side_path_check,
	output logic            stbg_meas,
	output logic [3:0]      res_meas_sel,
	output logic [3:0]      l2l_force,
	output logic            l2l_sense,
	// firing
	output logic [3:0]      fire_on
);
	////////////////////////////////////////////////////////////////
	typedef struct packed {
		logic [7:0] cmd;
		logic [7:0] resp;
		logic [3:0] cont;
		logic [3:0] arm_nib;
		logic       arm_pend;
		logic [3:0] armed;
		logic [3:0] fire;
		logic [3:0] fire_out;
		logic       cont_test;
		logic       stbg;
		logic [3:0] res_sel;
		logic [3:0] l2l_f;
		logic       l2l_s;
		logic       tog_seen;
	} core_t;

	core_t st_r;
	core_t st_nxt;

	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	logic [7:0]       cap_byte;
	logic [CNT_W-1:0] cap_cnt;
	logic             cap_tog;
	logic [1:0]       fen_s;
	logic [3:0]       cont_s;
	logic [7:0]       meas_s;
	logic             tog_s;
	logic             word_edge;
	logic             acc;

	function automatic logic [3:0] onehot(input logic [1:0] sel);
		onehot = 4'h1 << sel;
	endfunction

	function automatic logic is_known(input logic [7:0] c);
		is_known = (c == CMD_ECHO) || (c == CMD_CFG) || (c == CMD_STBG) || (c == CMD_CONT)
			|| (c == CMD_L2L_SNS) || ((c[7:4] == NIB_RES) && (c[3:2] == 2'h0))
			|| ((c[7:4] == NIB_L2L) && (c[3:2] == 2'h0));
	endfunction

	////////////////////////////////////////////////////////////////
	spi_link u_link (
		.srst     (srst),
		.sclk     (sclk),
		.cs_n     (cs_n),
		.mosi     (mosi),
		.miso     (serial_result_out_pin),
		.miso_oe  (serial_result_out_oe),
		.resp     (st_r.resp),
		.cap_byte (cap_byte),
		.cap_cnt  (cap_cnt),
		.cap_tog  (cap_tog)
	);

	// cap_byte and cap_cnt are quiet once the toggle is seen, so they need no synchroniser
	sync2 #(.W(SYNC_W)) u_sync (
		.clk  (clk),
		.srst (srst),
		.d    ({fen, low_side_path_ok, meas_result, cap_tog}),
		.q    ({fen_s, cont_s, meas_s, tog_s})
	);

	assign word_edge = tog_s != st_r.tog_seen;
	assign acc       = word_edge && (cap_cnt == WORD_LEN); // [R3] [R24]

	////////////////////////////////////////////////////////////////
	always_comb begin
		st_nxt          = st_r;
		st_nxt.tog_seen = tog_s;
		if (word_edge && !acc) begin
			st_nxt.arm_pend = 1'b0; // [R3] [R5]
		end
		if (acc) begin
			st_nxt.cmd       = cap_byte; // [R21]
			st_nxt.cont      = 4'h0; // [R12] [R13]
			st_nxt.cont_test = 1'b0;
			st_nxt.stbg      = 1'b0;
			st_nxt.res_sel   = 4'h0;
			st_nxt.l2l_f     = 4'h0;
			st_nxt.l2l_s     = 1'b0;
			st_nxt.arm_pend  = 1'b0; // [R5]
			if (cap_byte[7:4] == NIB_ARM && cap_byte[3:2] == 2'h0 && cap_byte[1:0] != SEL_MAX) begin
				st_nxt.arm_pend = 1'b1; // [R19]
				st_nxt.arm_nib  = cap_byte[7:4];
				st_nxt.armed    = (cap_byte == CMD_ARM_1) ? GRP1_MASK
					: (cap_byte == CMD_ARM_2) ? GRP2_MASK : (GRP1_MASK | GRP2_MASK);
			end else if (cap_byte[7:4] == NIB_FIRE) begin
				// fire byte needs the arm just before, inverted nibble, and no FET on
				if (st_r.arm_pend && (cap_byte[7:4] == ~st_r.arm_nib) && (st_r.fire_out == 4'h0)) begin // [R4] [R5]
					st_nxt.fire = (st_r.fire & ~st_r.armed) | (cap_byte[3:0] & st_r.armed); // [R19]
				end
			end else begin
				st_nxt.cont_test = (cap_byte == CMD_CONT); // [R11]
				st_nxt.stbg      = (cap_byte == CMD_STBG); // [R15]
				st_nxt.l2l_s     = (cap_byte == CMD_L2L_SNS); // [R17]
				if (cap_byte[7:4] == NIB_RES && cap_byte[3:2] == 2'h0) begin
					st_nxt.res_sel = onehot(cap_byte[1:0]); // [R15]
				end
				if (cap_byte[7:4] == NIB_L2L && cap_byte[3:2] == 2'h0) begin
					st_nxt.l2l_f = onehot(cap_byte[1:0]); // [R15]
				end
				// nop and unknown bytes leave every mode cleared
				if (!is_known(cap_byte)) begin
					st_nxt.cmd = CMD_NOP; // [R22]
				end
			end
		end else if (st_r.cont_test) begin
			// only local low-side paths feed this latch
			st_nxt.cont = st_r.cont | cont_s; // [R11] [R18]
		end
		// a low enable pin drops the matching pair at once
		st_nxt.fire_out = st_nxt.fire & {{2{fen_s[1]}}, {2{fen_s[0]}}};
		// reply built from the standing command, loaded at the next select fall
		unique case (1'b1)
			(st_r.cmd == CMD_ECHO): st_nxt.resp = ECHO_REPLY; // [R1]
			(st_r.cmd == CMD_CFG): st_nxt.resp = {VARIANT_ID, 5'h00, fen_s}; // [R10] [R2]
			(st_r.cmd == CMD_CONT): st_nxt.resp = {4'h0, st_r.cont}; // [R2] [R14]
			(st_r.cmd[7:4] == NIB_ARM): st_nxt.resp = st_r.cmd;
			(st_r.cmd[7:4] == NIB_FIRE): st_nxt.resp = st_r.cmd;
			(st_r.cmd == CMD_NOP): st_nxt.resp = st_r.resp; // [R22]
			default: st_nxt.resp = meas_s; // [R15] [R17]
		endcase
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			st_r <= '0; // [R23]
		end else begin
			st_r <= st_nxt;
		end
	end

	assign low_side_path_check = st_r.cont_test;
	assign stbg_meas           = st_r.stbg;
	assign res_meas_sel        = st_r.res_sel;
	assign l2l_force           = st_r.l2l_f;
	assign l2l_sense           = st_r.l2l_s;
	assign fire_on             = st_r.fire_out;

	////////////////////////////////////////////////////////////////

	sequence echo_taken;
		acc && cap_byte == CMD_ECHO;
	endsequence
	sequence echo_settled;
		##2 st_r.resp == ECHO_REPLY;
	endsequence

	chk_echo_reply: assert property (echo_taken |-> echo_settled) // [R1]
		else $error("echo command did not load echo reply");
	chk_cfg_zero_fill: assert property ((st_r.cmd == CMD_CFG) && $past(st_r.cmd) == CMD_CFG
		|-> st_r.resp[6:2] == 5'h00) // [R2]
		else $error("config reply unused bits not zero");
	chk_bad_length: assert property (word_edge && cap_cnt != WORD_LEN |=> $stable(st_r.cmd)) // [R3]
		else $error("short or long word changed the command");
	chk_fire_lock: assert property (acc && st_r.fire_out != 4'h0 |=> $stable(st_r.fire)) // [R4]
		else $error("fire state changed while a driver was on");
	chk_seq_break: assert property (acc && !st_r.arm_pend |=> $stable(st_r.fire)) // [R5]
		else $error("fire byte acted without preceding arm");
	chk_variant_bit: assert property ((st_r.cmd == CMD_CFG)[*2] |-> st_r.resp[7] == VARIANT_ID) // [R10]
		else $error("config reply variant bit wrong");
	chk_cont_clear: assert property (acc && cap_byte != CMD_CONT |=> st_r.cont == 4'h0) // [R12]
		else $error("continuity latch not cleared after transfer");
	chk_undef_clear: assert property (acc && !is_known(cap_byte) && cap_byte[7:4] != NIB_ARM
		&& cap_byte[7:4] != NIB_FIRE |=> !st_r.cont_test && !st_r.stbg && st_r.res_sel == 4'h0
		&& st_r.l2l_f == 4'h0 && !st_r.l2l_s) // [R22]
		else $error("undefined command left a mode active");

	sequence arm_taken;
		acc && cap_byte[7:4] == NIB_ARM && cap_byte[3:2] == 2'h0 && cap_byte[1:0] != SEL_MAX;
	endsequence
	sequence modes_idle;
		!st_r.cont_test && !st_r.stbg && st_r.res_sel == 4'h0 && st_r.l2l_f == 4'h0 && !st_r.l2l_s;
	endsequence

	chk_arm_clears: assert property (arm_taken |=> modes_idle) // [R19]
		else $error("arm byte left a diagnostic mode active");
	chk_fen_gate_lo: assert property (!fen_s[0] |=> st_r.fire_out[1:0] == 2'h0) // [R19]
		else $error("first pair driven while its enable is low");
	chk_fen_gate_hi: assert property (!fen_s[1] |=> st_r.fire_out[3:2] == 2'h0) // [R19]
		else $error("second pair driven while its enable is low");
	// between accepted words the continuity latch may only gain bits
	chk_cont_sticky: assert property (st_r.cont_test && !word_edge
		|=> (st_r.cont & $past(st_r.cont)) == $past(st_r.cont)) // [R11]
		else $error("continuity latch lost a bit before transfer");
	chk_cmd_pipe: assert property (acc |=> st_r.cmd == $past(cap_byte) || st_r.cmd == CMD_NOP) // [R14] [R21]
		else $error("accepted word not taken as the standing command");
	chk_reset_idle: assert property (disable iff (1'b0) srst
		|=> st_r.fire_out == 4'h0 && st_r.resp == 8'h00 && st_r.cmd == CMD_NOP) // [R23]
		else $error("reset left a driver on or a reply pending");
	chk_mode_onehot: assert property ($onehot0(st_r.res_sel) && $onehot0(st_r.l2l_f)) // [R15]
		else $error("more than one measurement channel selected");
endmodule // squib_spi_command_port

// ### hw/sync2.sv
// two-flop level synchroniser, vector of independent levels
`timescale 1ns/100ps
module sync2 #(
	parameter int W = 1
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         srst,
	// levels
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] hold;
	} sync_t;

	sync_t st_r;
	sync_t st_nxt;

	always_comb begin
		st_nxt.meta = d;
		st_nxt.hold = st_r.meta;
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign q = st_r.hold;
endmodule // sync2

// ### shared/squib_pkg.sv
// constants shared by the squib serial command port
// How it works
// R1: echo command answers with fixed echo byte
// R2: unused reply bits read as zero
// R3: only exactly eight-bit words execute
// R4: second program byte ignored while firing
// R5: program bytes must be consecutive words
// R6: clock low at select: idle-low mode
// R7: clock high at select: idle-high mode
// R8: sample on rise, shift out on fall
// R9: data output floats while deselected
// R10: config reply bit seven is variant bit
// R11: continuity command latches per-channel result
// R12: continuity latch cleared after next word
// R13: sent results cleared at select rise
// R14: each reply carries previous command's result
// R15: decode short, resistance, loop-short commands
// R16: host enables low side before high
// R17: sense-only loop-short command on second part
// R18: continuity reports local low sides only
// R19: arm then fire same in both setups
// R20: bytes move most significant bit first
// R21: latch command at rise, results at fall
// R22: nop or unknown command clears modes
// R23: reset clears functions and shift state
// R24: bit count cleared at fall, checked at rise
package squib_pkg;
	localparam int          WORD_BITS    = 8;
	localparam int          CNT_W        = 4;
	localparam logic [3:0]  WORD_LEN     = 4'h8;
	localparam logic [3:0]  CNT_MAX      = 4'h9;
	localparam logic [7:0]  CMD_NOP      = 8'h00;
	localparam logic [7:0]  CMD_ECHO     = 8'h96;
	localparam logic [7:0]  ECHO_REPLY   = 8'h69;
	localparam logic [7:0]  CMD_CFG      = 8'hc8;
	localparam logic [7:0]  CMD_STBG     = 8'hc1;
	localparam logic [7:0]  CMD_CONT     = 8'hc2;
	localparam logic [7:0]  CMD_L2L_SNS  = 8'he8;
	localparam logic [7:0]  CMD_ARM_1    = 8'ha0;
	localparam logic [7:0]  CMD_ARM_2    = 8'ha1;
	localparam logic [7:0]  CMD_ARM_ALL  = 8'ha2;
	localparam logic [3:0]  NIB_RES      = 4'hd;
	localparam logic [3:0]  NIB_L2L      = 4'he;
	localparam logic [3:0]  NIB_FIRE     = 4'h5;
	localparam logic [3:0]  NIB_ARM      = 4'ha;
	localparam logic [1:0]  SEL_MAX      = 2'h3;
	localparam logic [3:0]  GRP1_MASK    = 4'h3;
	localparam logic [3:0]  GRP2_MASK    = 4'hc;
	localparam int          SYNC_W       = 15;
endpackage

// ### testbench/spi_host.sv
// host serial master model for the squib command port
`timescale 1ns/100ps
module spi_host (
	// core clock, frames start on its falling edge
	input  wire logic clk,
	// serial pins
	output logic      sclk,
	output logic      cs_n,
	output logic      mosi,
	input  wire logic miso
);
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		mosi = 1'b0;
	end
	// tx is left aligned so 7 and 9 bit frames share one path
	task automatic xfer(input logic [8:0] tx, input int n, input logic hi, output logic [7:0] rx);
		rx = 8'h00;
		@(negedge clk);
		sclk = hi;
		mosi = tx[8];
		@(negedge clk);
		cs_n = 1'b0;
		#6;
		if (hi) begin
			sclk = 1'b0;
			#6;
		end
		for (int i = 0; i < n; i++) begin
			mosi = tx[8-i];
			#6;
			sclk = 1'b1;
			rx = {rx[6:0], miso};
			#6;
			sclk = 1'b0;
		end
		// clock stands still low until the next frame
		@(negedge clk);
		cs_n = 1'b1;
		mosi = ~mosi;
		// long gap so each reply is settled before the next fall
		repeat (10) @(negedge clk);
	endtask
endmodule // spi_host

// ### testbench/squib_spi_command_port_tb_top.sv
// self-checking bench for the squib serial command port
`timescale 1ns/100ps
module squib_spi_command_port_tb_top;
	import squib_pkg::*;
	logic       clk, srst, sclk, cs_n, mosi, so_pin, so_oe, lsc, stbg, l2ls;
	logic [1:0] fen;
	logic [3:0] lsok, rsel, l2lf, fire;
	logic [7:0] meas, rx;
	wire        so_wire = so_oe ? so_pin : 1'bz;
	int         bad_count, num_checks;

	squib_spi_command_port squib_spi_command_port_inst (
		.clk(clk), .srst(srst), .sclk(sclk), .cs_n(cs_n), .mosi(mosi),
		.serial_result_out_pin(so_pin), .serial_result_out_oe(so_oe),
		.fen(fen), .low_side_path_ok(lsok), .meas_result(meas),
		.low_side_path_check(lsc), .stbg_meas(stbg), .res_meas_sel(rsel),
		.l2l_force(l2lf), .l2l_sense(l2ls), .fire_on(fire));
	spi_host spi_host_inst (.clk(clk), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(so_wire));

	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic send(input logic [7:0] b, input logic hi = 1'b0);
		spi_host_inst.xfer({b, 1'b0}, 8, hi, rx);
	endtask
	task automatic wrap_up;
		$display("checks=%0d bad=%0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////
	task automatic t_echo;
		send(CMD_ECHO);
		send(CMD_NOP, 1'b1);
		chk(rx, ECHO_REPLY);
		chk(so_oe, 1'b0);
	endtask
	task automatic t_cfg;
		fen = 2'h2;
		send(CMD_CFG, 1'b1);
		send(CMD_NOP);
		chk(rx, 8'h02);
	endtask
	task automatic t_cont;
		lsok = 4'h5;
		send(CMD_CONT);
		chk(lsc, 1'b1);
		lsok = 4'h0;
		send(CMD_CONT);
		chk(rx, 8'h05);
		send(CMD_NOP);
		chk(rx, 8'h00);
		chk(lsc, 1'b0);
	endtask
	task automatic t_meas;
		logic [7:0] c [10] = '{CMD_STBG, 8'hd0, 8'hd1, 8'hd2, 8'hd3, 8'he0, 8'he1, 8'he2, 8'he3, CMD_L2L_SNS};
		logic [9:0] e;
		for (int i = 0; i < 10; i++) begin
			e = (i == 0) ? 10'h200 : (i < 5) ? (10'h010 << i) : (i < 9) ? (10'h001 << (i - 4)) : 10'h001;
			meas = 8'h30 + 8'(i);
			send(c[i]);
			chk({stbg, rsel, l2lf, l2ls}, e);
			send(CMD_NOP);
			chk(rx, meas);
		end
		chk({stbg, rsel, l2lf, l2ls}, 10'h000);
	endtask
	// the 9- and 7-bit frames leave STBG and CONT in the shifter, so a missing length check shows; the last one leaves NOP
	task automatic t_short;
		fen = 2'h3;
		spi_host_inst.xfer(9'h1c1, 9, 1'b0, rx);
		chk(stbg, 1'b0);
		spi_host_inst.xfer({CMD_CONT[6:0], 2'b00}, 7, 1'b0, rx);
		chk(lsc, 1'b0);
		send(CMD_ARM_1);
		spi_host_inst.xfer(9'h000, 7, 1'b0, rx);
		send(8'h53);
		chk(fire, 4'h0);
	endtask
	task automatic t_fire;
		fen = 2'h3;
		send(CMD_ARM_1);
		send(CMD_NOP);
		send(8'h53);
		chk(fire, 4'h0);
		// low side of pair A (bit 0) on before its high side (bit 1)
		send(CMD_ARM_1);
		send(8'h51);
		chk(rx, CMD_ARM_1);
		chk(fire, 4'h1);
		fen = 2'h0;
		repeat (8) @(negedge clk);
		chk(fire, 4'h0);
		send(CMD_ARM_1);
		send(8'h53);
		chk(fire, 4'h0);
		fen = 2'h3;
		repeat (8) @(negedge clk);
		chk(fire, 4'h3);
		send(CMD_ARM_2);
		send(8'h5c);
		chk(fire, 4'h3);
		fen = 2'h0;
		repeat (8) @(negedge clk);
		chk(fire, 4'h0);
	endtask

	////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	initial begin
		// raised just after time zero so the link's asynchronous clears see an edge
		#1;
		srst = 1'b1;
		fen = 2'h0;
		lsok = 4'h0;
		meas = 8'h00;
		bad_count = 0;
		num_checks = 0;
		repeat (12) @(negedge clk);
		srst = 1'b0;
		repeat (6) @(negedge clk);
		chk({fire, lsc, stbg, l2ls}, 7'h00);
		t_echo;
		t_cfg;
		t_cont;
		t_meas;
		t_short;
		t_fire;
		wrap_up;
	end
	// frames take about 0.75 us each, well under this bound
	initial begin
		#1000000;
		bad_count++;
		wrap_up;
	end
endmodule // squib_spi_command_port_tb_top
